/* dlh_control.sv */
// Data-link controller pair control: register, framer tx, checked rx
//
// Behaviour
// - Select bit chooses bit- or message-oriented mode
// - Append bit adds checksum after message frames
// - Append bit ignored in bit-oriented mode
// - Fill bit sends only flags, overriding frames but not a checksum already under way
// - Flags sent in message mode whenever no frame waits
// - Fill bit ignored in bit-oriented mode
// - Forced abort sends seven or more ones
// - Abrupt switch to bit mode sends zero, seven ones
// - Auto abort disable suppresses that sequence
// - Receive checksum verified in message mode unless check disabled
// - Duplicate discard drops frames matching stored copy
//
// The APB slave port and the register addresses were left to the implementer.
`include "dlh_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module dlh_control #(
    parameter int RX_DEPTH = 32
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Register bus
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Outbound message octets
    input wire dlh_pkg::dlh_octet_t tx_data,
    input wire logic tx_last,
    input wire logic tx_valid,
    output logic tx_ready,
    input wire logic [5:0] bos_code,
    // Outbound serial data-link bit
    input wire logic tx_bit_en,
    output logic tx_bit,
    // Inbound frame octets from the deframer
    input wire dlh_pkg::dlh_octet_t rx_data,
    input wire logic rx_last,
    input wire logic rx_valid,
    // Inbound result and stored-frame read port
    output logic rx_frame_ok,
    output logic rx_fcs_error,
    output logic rx_dup_drop,
    input wire logic [$clog2(RX_DEPTH)-1:0] rx_rd_addr,
    output dlh_pkg::dlh_octet_t rx_rd_data
);
    import dlh_pkg::*;

    localparam int LW = $clog2(RX_DEPTH + 1);
    localparam int AW = $clog2(RX_DEPTH);

    initial begin
        if (RX_DEPTH < 2 || RX_DEPTH > 255) begin
            $error("RX_DEPTH must lie between 2 and 255");
        end
    end

    // Bytewise reflected checksum update
    function automatic logic [15:0] crc_step(input logic [15:0] c,
                                             input logic [7:0] d);
        logic [15:0] r;
        r = c;
        for (int i = 0; i < 8; i++) begin
            if (r[0] ^ d[i]) begin
                r = (r >> 1) ^ `DLH_CRC_POLY;
            end else begin
                r = r >> 1;
            end
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Register bus slave
    logic [7:0] ctrl;
    logic st_ok, st_fcs, st_dup;
    logic [LW-1:0] slen;
    dlh_tx_state_e state;

    wire bus_setup = psel && !penable;
    wire bus_done = psel && penable;
    wire hit_ctrl = paddr == `DLH_CTRL_OFS;
    wire hit_stat = paddr == `DLH_STAT_OFS;
    wire ctrl_wr = bus_done && pwrite && hit_ctrl;
    wire [31:0] stat_word = (32'(slen) << `DLH_ST_LEN_LSB)
        | (32'(state != dlh_tx_idle) << `DLH_ST_BUSY_BIT)
        | (32'(st_dup) << `DLH_ST_DUP_BIT)
        | (32'(st_fcs) << `DLH_ST_FCS_BIT)
        | (32'(st_ok) << `DLH_ST_OK_BIT);
    wire [31:0] rd_word = hit_ctrl ? 32'(ctrl) :
        (hit_stat ? stat_word : 32'h0000_0000);
    assign pready = 1'b1;
    assign pslverr = bus_done && !hit_ctrl && !hit_stat;

    // Reserved bit seven is never stored, so it always reads zero
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ctrl <= `DLH_CTRL_RST;
        end else if (ctrl_wr) begin
            ctrl <= pwdata[7:0] & `DLH_CTRL_WMASK;
        end
    end

    // Read data is latched in setup so it stands through the access
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
        end else if (bus_setup && !pwrite) begin
            prdata <= rd_word;
        end
    end

    // Effective controls; bit mode masks the message-only fields
    wire sel = ctrl[`DLH_SEL_BIT];
    wire fcs_on = sel && ctrl[`DLH_FCS_EN_BIT];
    wire fill_on = sel && ctrl[`DLH_IDLE_BIT];
    wire abort_on = ctrl[`DLH_ABORT_BIT];
    wire dup_on = ctrl[`DLH_DUP_BIT];
    wire rx_chk_on = sel && !ctrl[`DLH_RXOFF_BIT];
    wire aoff = ctrl[`DLH_AOFF_BIT];

    ////////////////////////////////////////////////////////////////////
    // Two-entry buffer on the outbound octet path
    logic [8:0] fb [2];
    logic fb_wp, fb_rp;
    logic [1:0] fb_cnt;
    logic pop;
    wire fb_valid = fb_cnt != 2'h0;
    wire push = tx_valid && tx_ready;
    wire [8:0] fb_head = fb[fb_rp];
    assign tx_ready = fb_cnt != 2'h2;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            fb_wp <= 1'b0;
            fb_rp <= 1'b0;
            fb_cnt <= 2'h0;
        end else begin
            fb_wp <= fb_wp ^ push;
            fb_rp <= fb_rp ^ pop;
            fb_cnt <= fb_cnt + 2'(push) - 2'(pop);
        end
    end

    always_ff @(posedge core_clk) begin
        if (push) begin
            fb[fb_wp] <= {tx_last, tx_data};
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outbound octet selection and serialiser
    logic [7:0] sh, oct;
    logic [3:0] left;
    logic [2:0] ones;
    logic stf, oct_stf, pend, flush, phase, sel_q;
    logic [15:0] crc, next_crc;
    logic next_pend, next_flush, next_phase;
    dlh_tx_state_e next_state;

    wire empty = left == 4'h0;
    // A run of five stuffed ones is broken before any new octet
    wire stuff_now = ones == `DLH_STUFF_RUN;
    wire load = tx_bit_en && empty && !stuff_now;
    wire in_frame = state != dlh_tx_idle;
    wire mode_drop = sel_q && !sel && in_frame;
    wire [7:0] cur = empty ? oct : sh;
    wire cur_stf = empty ? oct_stf : stf;
    wire out_bit = stuff_now ? 1'b0 : cur[0];

    // Next octet and frame state; a mode switch outranks the strobe
    always_comb begin
        oct = `DLH_FLAG;
        oct_stf = 1'b0;
        pop = flush && fb_valid;
        next_state = state;
        next_crc = crc;
        next_pend = pend;
        next_flush = flush && !(fb_valid && fb_head[8]);
        next_phase = phase;
        if (mode_drop) begin
            next_state = dlh_tx_idle;
            next_pend = !aoff;
            next_flush = 1'b1;
        end else if (load && abort_on) begin
            oct = `DLH_ONES;
            next_state = dlh_tx_idle;
            next_flush = in_frame || flush;
        end else if (load && !sel) begin
            if (pend) begin
                oct = `DLH_AUTO_ABORT;
                next_pend = 1'b0;
            end else begin
                oct = phase ? {1'b0, bos_code, 1'b0} : `DLH_ONES;
                next_phase = !phase;
            end
        end else if (load) begin
            unique case (state)
                dlh_tx_idle: begin
                    next_pend = 1'b0;
                    if (!fill_on && !flush && fb_valid) begin
                        next_state = dlh_tx_data;
                        next_crc = `DLH_CRC_INIT;
                    end
                end
                dlh_tx_data: begin
                    if (fill_on) begin
                        next_state = dlh_tx_idle;
                        next_flush = 1'b1;
                    end else if (fb_valid) begin
                        oct = fb_head[7:0];
                        oct_stf = 1'b1;
                        pop = 1'b1;
                        next_crc = crc_step(crc, fb_head[7:0]);
                        if (fb_head[8]) begin
                            next_state = fcs_on ? dlh_tx_fcs_lo
                                : dlh_tx_idle;
                        end
                    end else begin
                        // Source ran dry mid-frame: abort it
                        oct = `DLH_ONES;
                        next_state = dlh_tx_idle;
                        next_flush = 1'b1;
                    end
                end
                dlh_tx_fcs_lo: begin
                    oct = ~crc[7:0];
                    oct_stf = 1'b1;
                    next_state = dlh_tx_fcs_hi;
                end
                dlh_tx_fcs_hi: begin
                    oct = ~crc[15:8];
                    oct_stf = 1'b1;
                    next_state = dlh_tx_idle;
                end
            endcase
        end
    end

    // Frame state registers
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state <= dlh_tx_idle;
            crc <= `DLH_CRC_INIT;
            pend <= 1'b0;
            flush <= 1'b0;
            phase <= 1'b0;
            sel_q <= 1'b0;
        end else begin
            state <= next_state;
            crc <= next_crc;
            pend <= next_pend;
            flush <= next_flush;
            phase <= next_phase;
            sel_q <= sel;
        end
    end

    // Serialiser: one bit per strobe, stuffed zero holds the shifter
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sh <= 8'h00;
            left <= 4'h0;
            stf <= 1'b0;
            ones <= 3'h0;
            tx_bit <= 1'b1;
        end else if (tx_bit_en) begin
            tx_bit <= out_bit;
            ones <= (!stuff_now && cur_stf && cur[0]) ? ones + 3'h1 : 3'h0;
            if (!stuff_now) begin
                sh <= cur >> 1;
                left <= (empty ? `DLH_OCT_BITS : left) - 4'h1;
                stf <= cur_stf;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Inbound frame check and duplicate discard, two banks
    dlh_octet_t rmem [2*RX_DEPTH];
    logic bank, match, over, rsvalid;
    logic [LW-1:0] ridx;
    logic [15:0] rcrc;

    wire fits = ridx < LW'(RX_DEPTH);
    wire [AW-1:0] widx = ridx[AW-1:0];
    wire same = fits && ridx < slen
        && rmem[{bank, widx}] == rx_data;
    wire match_n = match && same;
    wire over_n = over || !fits;
    wire [15:0] rcrc_n = crc_step(rcrc, rx_data);
    wire [LW-1:0] rlen = ridx + LW'(1);
    wire fcs_bad = rx_chk_on && rcrc_n != `DLH_CRC_GOOD;
    wire is_dup = dup_on && rsvalid && match_n
        && rlen == slen;
    wire frame_end = rx_valid && rx_last;
    wire keep = !fcs_bad && !is_dup && !over_n;

    // Octets land in the idle bank; the active bank is the stored copy
    always_ff @(posedge core_clk) begin
        if (rx_valid && fits) begin
            rmem[{!bank, widx}] <= rx_data;
        end
        rx_rd_data <= rmem[{bank, rx_rd_addr}];
    end

    // Running frame state
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ridx <= '0;
            match <= 1'b1;
            over <= 1'b0;
            rcrc <= `DLH_CRC_INIT;
        end else if (rx_valid) begin
            ridx <= rx_last ? '0 : rlen;
            match <= rx_last || match_n;
            over <= !rx_last && over_n;
            rcrc <= rx_last ? `DLH_CRC_INIT : rcrc_n;
        end
    end

    // Frame verdict; a kept frame becomes the stored copy
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            bank <= 1'b0;
            slen <= '0;
            rsvalid <= 1'b0;
            {rx_frame_ok, rx_fcs_error, rx_dup_drop} <= 3'h0;
            {st_ok, st_fcs, st_dup} <= 3'h0;
        end else begin
            rx_frame_ok <= frame_end && keep;
            rx_fcs_error <= frame_end && fcs_bad;
            rx_dup_drop <= frame_end && is_dup && !fcs_bad;
            if (frame_end) begin
                {st_ok, st_fcs, st_dup} <= {keep, fcs_bad, is_dup};
            end
            if (frame_end && keep) begin
                bank <= !bank;
                slen <= rlen;
                rsvalid <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks on the block's own behaviour
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence last_data_s;
        load && !abort_on && sel && state == dlh_tx_data
            && !fill_on && fb_valid && fb_head[8];
    endsequence

    reset_clear_a: assert property ($past(rst) |-> ctrl == 8'h00)
        else $error("control not clear after reset");
    bit_mode_a: assert property (!sel && !sel_q |=> state == dlh_tx_idle)
        else $error("frame state active in bit mode");
    fcs_append_a: assert property (last_data_s ##0 fcs_on [*1]
        |=> state == dlh_tx_fcs_lo)
        else $error("checksum not appended");
    fcs_skip_a: assert property (last_data_s ##0 !fcs_on
        |=> state == dlh_tx_idle)
        else $error("checksum appended while off");
    flag_fill_a: assert property (load && fill_on && !abort_on && !mode_drop
        |=> sh == 8'h3F && !stf)
        else $error("fill did not send a flag");
    idle_flag_a: assert property (load && sel && !abort_on && !mode_drop
        && state == dlh_tx_idle |=> sh == 8'h3F)
        else $error("idle did not send a flag");
    fill_ignore_a: assert property (load && !sel && !pend && !abort_on
        && !phase |=> sh == 8'h7F)
        else $error("bit mode fill leaked");
    force_abort_a: assert property (load && abort_on && !mode_drop
        |=> sh == 8'h7F && left == 4'h7 && !stf)
        else $error("forced abort octet wrong");
    auto_abort_a: assert property (mode_drop && !aoff
        |=> pend)
        else $error("auto abort not armed");
    no_auto_a: assert property (!pend && aoff |=> !pend)
        else $error("auto abort armed while disabled");
    rx_fcs_a: assert property (frame_end && !rx_chk_on
        |=> !rx_fcs_error)
        else $error("checksum checked while off");
    dup_keep_a: assert property (frame_end && !dup_on
        |=> !rx_dup_drop)
        else $error("frame dropped with discard off");

endmodule

`default_nettype wire

/* dlh_regs.svh */
// Register offsets, field positions, reset values and link constants
`ifndef DLH_REGS_SVH
`define DLH_REGS_SVH

// Word offsets on the register bus
`define DLH_CTRL_OFS 12'h000
`define DLH_STAT_OFS 12'h004

// Control register fields
`define DLH_SEL_BIT 0
`define DLH_FCS_EN_BIT 1
`define DLH_IDLE_BIT 2
`define DLH_ABORT_BIT 3
`define DLH_DUP_BIT 4
`define DLH_RXOFF_BIT 5
`define DLH_AOFF_BIT 6
`define DLH_CTRL_RST 8'h00
`define DLH_CTRL_WMASK 8'h7F

// Status register fields
`define DLH_ST_OK_BIT 0
`define DLH_ST_FCS_BIT 1
`define DLH_ST_DUP_BIT 2
`define DLH_ST_BUSY_BIT 3
`define DLH_ST_LEN_LSB 8

// Octets and checksum constants
`define DLH_FLAG 8'h7E
`define DLH_ONES 8'hFF
`define DLH_AUTO_ABORT 8'hFE
`define DLH_CRC_INIT 16'hFFFF
`define DLH_CRC_POLY 16'h8408
`define DLH_CRC_GOOD 16'hF0B8
`define DLH_STUFF_RUN 3'h5
`define DLH_OCT_BITS 4'h8

`endif

/* dlh_pkg.sv */
// Types shared by the data-link control block
package dlh_pkg;
    typedef logic [7:0] dlh_octet_t;
    typedef enum logic [1:0] {
        dlh_tx_idle,
        dlh_tx_data,
        dlh_tx_fcs_lo,
        dlh_tx_fcs_hi
    } dlh_tx_state_e;
endpackage

/* dlh_remote.sv */
// Remote terminal model: bit slots, line capture and frame decode
`include "dlh_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module dlh_remote (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Data-link line
    output logic tx_bit_en,
    input wire logic tx_bit,
    // Decoded octets and line statistics
    input wire logic clr,
    output logic oct_vld,
    output logic [7:0] oct_val,
    output logic [7:0] max_run,
    output logic [7:0] flags
);
    logic [7:0] raw, sh, pend, run;
    logic [3:0] nb;
    logic [1:0] cnt;
    logic pv, stuf;
    // One bit slot in four cycles
    assign tx_bit_en = cnt == 2'h0;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst)
            cnt <= 2'h0;
        else
            cnt <= cnt + 2'h1;
    end
    // Line bit taken two edges after its slot, when it has settled
    always @(posedge core_clk or posedge rst) begin
        oct_vld <= 1'b0;
        if (rst) begin
            run = 8'h00;
            nb = 4'h0;
            pv = 1'b0;
            max_run <= 8'h00;
            flags <= 8'h00;
        end else begin
            if (clr) begin
                max_run <= 8'h00;
                flags <= 8'h00;
            end
            if (cnt == 2'h2) begin
                stuf = !tx_bit && run == 8'h05;
                raw = {tx_bit, raw[7:1]};
                run = tx_bit ? run + 8'h01 : 8'h00;
                if (run > max_run)
                    max_run <= run;
                // Seven ones abort the frame being gathered
                if (run > 8'h06) begin
                    pv = 1'b0;
                    nb = 4'h0;
                end else if (raw == `DLH_FLAG) begin
                    flags <= flags + 8'h01;
                    oct_vld <= pv && nb == 4'h7;
                    oct_val <= pend;
                    pv = 1'b0;
                    nb = 4'h0;
                end else if (!stuf) begin
                    // Held back one octet, the flag may follow it
                    sh = {tx_bit, sh[7:1]};
                    nb = nb + 4'h1;
                    if (nb == 4'h8) begin
                        oct_vld <= pv;
                        oct_val <= pend;
                        pend = sh;
                        pv = 1'b1;
                        nb = 4'h0;
                    end
                end
            end
        end
    end
endmodule
`default_nettype wire

/* tb_top.sv */
// Self-checking bench for the data-link control block
`include "dlh_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import dlh_pkg::*;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, clr = 1'b0;
    logic tx_last = 1'b0, tx_valid = 1'b0, rx_last = 1'b0;
    logic rx_valid = 1'b0, ign = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rdv;
    logic [4:0] rx_rd_addr = 5'h00;
    logic [5:0] bos_code = 6'h00;
    dlh_octet_t tx_data = 8'h00, rx_data = 8'h00, rx_rd_data, oct_val;
    logic pready, pslverr, tx_ready, tx_bit, tx_bit_en, ok, fe, dd;
    logic oct_vld;
    logic [7:0] max_run, flags, st0;
    logic [65:0] e;
    logic [65:0] reg_q[$];
    logic [2:0] rx_q[$];
    dlh_octet_t oct_q[$], fr[$];
    int failures = 0, total_checks = 0, cyc = 0;

    always #5 core_clk = ~core_clk;

    dlh_control #(.RX_DEPTH(32)) i_dlh_control (
        .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .tx_data(tx_data),
        .tx_last(tx_last), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .bos_code(bos_code), .tx_bit_en(tx_bit_en), .tx_bit(tx_bit),
        .rx_data(rx_data), .rx_last(rx_last), .rx_valid(rx_valid),
        .rx_frame_ok(ok), .rx_fcs_error(fe), .rx_dup_drop(dd),
        .rx_rd_addr(rx_rd_addr), .rx_rd_data(rx_rd_data));
    dlh_remote i_dlh_remote (
        .core_clk(core_clk), .rst(rst), .tx_bit_en(tx_bit_en),
        .tx_bit(tx_bit), .clr(clr), .oct_vld(oct_vld), .oct_val(oct_val),
        .max_run(max_run), .flags(flags));

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic final_report;
        $display("checks=%0d failures=%0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Watchers: each result takes the oldest note of its kind
    always @(posedge core_clk) begin
        if (psel && penable && pready) begin
            e = reg_q.pop_front();
            chk({pslverr, prdata} & e[65:33], e[32:0]);
        end
        if (ok || fe || dd)
            chk({dd, fe, ok}, rx_q.pop_front());
        if (oct_vld && !ign)
            chk(oct_val, oct_q.pop_front());
    end
    // Hang guard, well above the length of the run
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 40000) begin
            failures++;
            final_report;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus master: request held until pready is seen at an edge
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, input logic [65:0] note);
        int n;
        n = 0;
        reg_q.push_back(note);
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rdv = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      input logic er);
        apb(1'b1, a, d, {1'b1, 32'h0, er, 32'h0});
    endtask
    task automatic rd(input logic [11:0] a, input logic [32:0] m,
                      input logic [32:0] x);
        apb(1'b0, a, 32'h0, {m, x});
    endtask
    task automatic ctl(input logic [6:0] v);
        wr(`DLH_CTRL_OFS, {25'h0, v}, 1'b0);
    endtask
    task automatic bits(input int n);
        repeat (n * 4) @(posedge core_clk);
    endtask
    // Settle, clear the line statistics, then watch n bits
    task automatic meas(input int s, input int n);
        bits(s);
        clr <= 1'b1;
        @(posedge core_clk);
        clr <= 1'b0;
        bits(n);
    endtask
    function automatic logic [15:0] crc(input logic [15:0] c,
                                        input dlh_octet_t d);
        for (int i = 0; i < 8; i++)
            c = (c[0] ^ d[i]) ? (c >> 1) ^ `DLH_CRC_POLY : c >> 1;
        return c;
    endfunction
    // Octet offered until taken; valid is lowered by the caller
    task automatic push(input dlh_octet_t d, input logic l);
        int n;
        n = 0;
        tx_data <= d;
        tx_last <= l;
        tx_valid <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (tx_ready !== 1'b1 && n < 3000);
    endtask
    task automatic frame(input int n, input logic app, input logic z);
        logic [15:0] c;
        dlh_octet_t d;
        c = `DLH_CRC_INIT;
        for (int i = 0; i < n; i++) begin
            d = z ? 8'h00 : 8'($urandom);
            c = crc(c, d);
            if (!ign)
                oct_q.push_back(d);
            push(d, i == n - 1);
        end
        if (app && !ign) begin
            oct_q.push_back(~c[7:0]);
            oct_q.push_back(~c[15:8]);
        end
        tx_valid <= 1'b0;
    endtask
    task automatic drain;
        int n;
        n = 0;
        while (oct_q.size() != 0 && n < 6000) begin
            @(posedge core_clk);
            n++;
        end
        chk(oct_q.size(), 0);
    endtask
    task automatic mkfr(input int n);
        logic [15:0] c;
        c = `DLH_CRC_INIT;
        fr = {};
        repeat (n) begin
            fr.push_back(8'($urandom));
            c = crc(c, fr[$]);
        end
        fr.push_back(~c[7:0]);
        fr.push_back(~c[15:8]);
    endtask
    // Inbound frame, first octet spoiled when bad is set
    task automatic rxf(input logic bad, input logic [2:0] x);
        rx_q.push_back(x);
        for (int i = 0; i < fr.size(); i++) begin
            rx_data <= fr[i] ^ {7'h0, bad && i == 0};
            rx_last <= i == fr.size() - 1;
            rx_valid <= 1'b1;
            @(posedge core_clk);
        end
        rx_valid <= 1'b0;
        rx_last <= 1'b0;
        repeat (3) @(posedge core_clk);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        int n;
        void'($urandom(32'hE2ADC69A));
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        rd(`DLH_CTRL_OFS, 33'h1_FFFF_FFFF, 33'h0);
        st0 = 8'($urandom) & 8'h7F;
        ctl(st0[6:0]);
        rd(`DLH_CTRL_OFS, 33'h1_FFFF_FFFF, {25'h0, st0});
        wr(12'h008, 32'h1, 1'b1);
        rd(12'h008, 33'h1_FFFF_FFFF, 33'h1_0000_0000);
        $display("test registers done");
        ctl(7'h01);
        meas(8, 40);
        chk(max_run, 8'h06);
        chk(flags > 8'h03, 1'b1);
        ctl(7'h09);
        meas(8, 40);
        chk(max_run > 8'h06, 1'b1);
        $display("test idle and abort done");
        ctl(7'h03);
        frame(5, 1'b1, 1'b0);
        drain;
        ctl(7'h01);
        frame(3, 1'b0, 1'b0);
        drain;
        $display("test frames done");
        ctl(7'h05);
        fork
            frame(4, 1'b0, 1'b0);
        join_none
        meas(8, 40);
        chk(tx_ready, 1'b0);
        chk(max_run, 8'h06);
        chk(oct_q.size() != 0, 1'b1);
        ctl(7'h01);
        wait fork;
        drain;
        $display("test flag fill done");
        ign <= 1'b1;
        ctl(7'h06);
        meas(16, 60);
        chk(flags, 8'h00);
        chk(max_run, 8'h08);
        $display("test bit mode done");
        ctl(7'h01);
        mkfr(6);
        rxf(1'b0, 3'b001);
        chk(rx_rd_data, fr[0]);
        rxf(1'b1, 3'b010);
        ctl(7'h21);
        rxf(1'b1, 3'b001);
        ctl(7'h11);
        mkfr(5);
        rxf(1'b0, 3'b001);
        rxf(1'b0, 3'b100);
        ctl(7'h01);
        rxf(1'b0, 3'b001);
        ctl(7'h00);
        rxf(1'b1, 3'b001);
        $display("test receive done");
        for (int a = 0; a < 2; a++) begin
            ctl({a[0], 6'h03});
            fork
                frame(24, 1'b1, 1'b1);
            join_none
            n = 0;
            do begin
                rd(`DLH_STAT_OFS, 33'h0, 33'h0);
                n++;
            end while (rdv[`DLH_ST_BUSY_BIT] !== 1'b1 && n < 300);
            bits(16);
            ctl({a[0], 6'h00});
            meas(0, 60);
            if (a == 0)
                chk(max_run > 8'h0E, 1'b1);
            else
                chk(max_run, 8'h08);
            wait fork;
        end
        $display("test mode switch done");
        final_report;
    end
endmodule
`default_nettype wire
